// File: tb/ebtcp_timer_assertions.sv
// Checker of the timer's bus answers and interrupt output, bound to the top module.
module ebtcp_timer_chk (
  input wire logic        CLK_SYS_IN,
  input wire logic        RESET_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        EXTERNAL_COUNT_INPUT_IN,
  input wire logic        SLEEP_IN,
  input wire logic        IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc;
  logic wr_int;
  logic mapped;
  assign acc    = PSEL_IN && PENABLE_IN;
  assign wr_int = acc && PWRITE_IN && PADDR_IN == ebtcp_pkg::ADDR_INTCTL;
  assign mapped = PADDR_IN inside {ebtcp_pkg::ADDR_COUNT, ebtcp_pkg::ADDR_OPTION,
                                   ebtcp_pkg::ADDR_INTCTL};
  default clocking @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  sequence s_read;
    PSEL_IN && !PENABLE_IN && !PWRITE_IN ##1 acc && !PWRITE_IN;
  endsequence
  property p_ready;
    acc |-> PREADY_OUT;
  endproperty
  property p_slverr;
    PSLVERR_OUT == (acc && !mapped);
  endproperty
  property p_rd_upper;
    s_read |-> PRDATA_OUT[31:8] == 24'h000000;
  endproperty
  property p_rd_unmapped;
    s_read |-> mapped || PRDATA_OUT == 32'h00000000;
  endproperty
  // Only software may take the request away, never the hardware.
  property p_irq_hold;
    IRQ_OUT && !wr_int |=> IRQ_OUT;
  endproperty
  property p_irq_keep;
    wr_int && PWDATA_IN[5] && PWDATA_IN[2] && IRQ_OUT |=> IRQ_OUT;
  endproperty
  property p_irq_off;
    wr_int && !PWDATA_IN[5] |=> !IRQ_OUT;
  endproperty
  property p_sleep;
    SLEEP_IN && !wr_int |=> !$rose(IRQ_OUT);
  endproperty
  a_ready: assert property (p_ready) else $error("ready low in access");
  a_slverr: assert property (p_slverr) else $error("slave error mismatch");
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  a_irq_keep: assert property (p_irq_keep) else $error("flag lost on write");
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  a_sleep: assert property (p_sleep) else $error("irq rose in sleep");
endmodule : ebtcp_timer_chk

bind ebtcp_timer ebtcp_timer_chk i_ebtcp_timer_chk (.*);

// File: tb/ebtcp_timer_bench.sv
// Self-checking bench for the prescaled 8-bit timer.
module ebtcp_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin = 1'b0;
  logic        sleep = 1'b0;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  c0;
  logic [7:0]  c1;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;
  always #20 clk = ~clk;
  ebtcp_timer i_ebtcp_timer (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXTERNAL_COUNT_INPUT_IN(pin),
    .SLEEP_IN(sleep), .IRQ_OUT(irq));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(output logic [7:0] v);
    apb(1'b0, ebtcp_pkg::ADDR_COUNT, 32'h00000000);
    v = rd[7:0];
  endtask : rdc
  // Setup edges of the two reads lie k+3 clocks apart, so the delta is exact.
  task automatic span(input int k, input logic [7:0] e, input string n);
    logic [7:0] d;
    rdc(c0);
    repeat (k) @(posedge clk);
    rdc(c1);
    d = c1 - c0;
    chk(n, {24'h000000, e}, {24'h000000, d});
  endtask : span
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ebtcp_pkg::ADDR_OPTION, 32'h0);
    chk("option reset", 32'h3F, rd);
    apb(1'b0, ebtcp_pkg::ADDR_INTCTL, 32'h0);
    chk("intctl reset", 32'h00, rd);
    rdc(c0);
    chk("count reset", 32'h0, {24'h0, c0});
    apb(1'b1, 8'h0C, 32'hFF);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, ebtcp_pkg::ADDR_OPTION, 32'h08);
    span(37, 8'h0A, "timer rate");
    apb(1'b1, ebtcp_pkg::ADDR_COUNT, 32'hFFFFFF30);
    repeat (39) @(posedge clk);
    rdc(c0);
    chk("stall", 32'h38, {24'h0, c0});
    apb(1'b1, ebtcp_pkg::ADDR_COUNT, 32'hFE);
    repeat (30) @(posedge clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b0, ebtcp_pkg::ADDR_INTCTL, 32'h0);
    chk("overflow flag", 32'h04, rd);
    // Enable, mask, enable again, then clear: the line must follow each step.
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ebtcp_pkg::ADDR_INTCTL, (i == 1) ? 32'h04 : (i == 3) ? 32'h20 : 32'h24);
      repeat (5) @(posedge clk);
      chk("irq line", {31'h0, i == 0 || i == 2}, {31'h0, irq});
    end
    sleep <= 1'b1;
    span(37, 8'h00, "sleep");
    sleep <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, ebtcp_pkg::ADDR_OPTION, r);
      span(1021, 8'(128 >> r), "prescale");
    end
    // Writes come sooner than the slowest tap rises, so only clearing keeps it at zero.
    repeat (3) begin
      apb(1'b1, ebtcp_pkg::ADDR_COUNT, 32'h00);
      repeat (400) @(posedge clk);
    end
    rdc(c0);
    chk("prescaler clear", 32'h0, {24'h0, c0});
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, ebtcp_pkg::ADDR_OPTION, 32'h28 | (e << 4));
      apb(1'b0, ebtcp_pkg::ADDR_OPTION, 32'h0);
      chk("option", 32'h28 | (e << 4), rd);
      rdc(c0);
      pin <= 1'b1;
      repeat (20) @(posedge clk);
      rdc(c1);
      chk("rise", 32'(e == 0), {24'h0, 8'(c1 - c0)});
      pin <= 1'b0;
      repeat (20) @(posedge clk);
      rdc(c0);
      chk("fall", 32'(e), {24'h0, 8'(c0 - c1)});
    end
    // Counter mode through the 1:2 prescaler: four rising pin edges give two increments.
    apb(1'b1, ebtcp_pkg::ADDR_OPTION, 32'h20);
    apb(1'b1, ebtcp_pkg::ADDR_COUNT, 32'h00);
    repeat (10) @(posedge clk);
    repeat (4) begin
      pin <= 1'b1;
      repeat (20) @(posedge clk);
      pin <= 1'b0;
      repeat (20) @(posedge clk);
    end
    rdc(c0);
    chk("prescaled count", 32'h2, {24'h0, c0});
    end_sim();
  end
endmodule : ebtcp_timer_bench

// File: verilog/ebtcp_pkg.sv
// Package with the register map, field layout and state types of the prescaled 8-bit timer.
package ebtcp_pkg;

  // Clock and instruction cycle timing.
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned INSTR_PERIOD_NS = 160;
  localparam int unsigned INSTR_CYCLES    = INSTR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PHASE_W         = $clog2(INSTR_CYCLES);
  localparam logic [PHASE_W-1:0] PHASE_ONE = PHASE_W'(1);
  localparam logic [PHASE_W-1:0] PHASE_Q2  = PHASE_W'(1);
  localparam logic [PHASE_W-1:0] PHASE_Q4  = PHASE_W'(INSTR_CYCLES - 1);

  // Register byte addresses on the APB.
  localparam int unsigned  ADDR_W      = 8;
  localparam logic [7:0]   ADDR_COUNT  = 8'h00;
  localparam logic [7:0]   ADDR_OPTION = 8'h04;
  localparam logic [7:0]   ADDR_INTCTL = 8'h08;

  // Option register layout.
  localparam int unsigned  OPT_SRC_BIT    = 5;
  localparam int unsigned  OPT_EDGE_BIT   = 4;
  localparam int unsigned  OPT_ASSIGN_BIT = 3;
  localparam int unsigned  OPT_RATE_LSB   = 0;
  localparam int unsigned  RATE_W         = 3;
  localparam logic         OPT_BIT_RESET  = 1'b1;
  localparam logic [2:0]   OPT_RATE_RESET = 3'h7;

  // Interrupt control register layout.
  localparam int unsigned  INT_GLOBAL_BIT = 7;
  localparam int unsigned  INT_PERIPH_BIT = 6;
  localparam int unsigned  INT_IE_BIT   = 5;
  localparam int unsigned  INT_FLAG_BIT = 2;

  localparam int unsigned  DATA_W      = 32;
  localparam int unsigned  CNT_W       = 8;
  localparam int unsigned  PSC_W       = 8;
  localparam logic [7:0]   COUNT_RESET = 8'h00;
  localparam logic [7:0]   COUNT_MAX   = 8'hFF;
  localparam logic [7:0]   COUNT_ONE   = 8'h01;
  localparam logic [7:0]   PSC_RESET   = 8'h00;
  localparam logic [7:0]   PSC_ONE     = 8'h01;
  localparam logic [7:0]   BYTE_ZERO   = 8'h00;
  localparam logic [23:0]  UPPER_ZERO  = 24'h000000;

  // Write stall after a count write: two instruction ticks are dropped.
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_WAIT1 = 3'b010,
    ST_WAIT2 = 3'b100
  } ebtcp_stall_t;

  typedef struct packed {
    logic             src_sel;
    logic             edge_sel;
    logic             assign_n;
    logic [RATE_W-1:0] rate;
  } ebtcp_opt_t;

  typedef struct packed {
    logic global_ie;
    logic periph_ie;
    logic ovf_ie;
    logic ovf_flag;
  } ebtcp_intctl_t;

  typedef struct packed {
    logic [CNT_W-1:0]   count;
    ebtcp_opt_t         opt;
    ebtcp_intctl_t      ictl;
    ebtcp_stall_t       stall;
    logic [PHASE_W-1:0] phase;
    logic               sync1;
    logic               sync2;
    logic               sync3;
    logic               ext_lvl;
    logic               samp;
    logic [7:0]         rdata;
  } ebtcp_state_t;

  typedef struct packed {
    logic [PSC_W-1:0] div;
  } ebtcp_psc_state_t;

endpackage : ebtcp_pkg

// File: verilog/ebtcp_prescaler.sv
// Dedicated 8-bit prescaler with a selectable power-of-two output tap.
module ebtcp_prescaler (
  // Clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           reset_n_in,
  // Control
  input  wire logic                           clear_in,
  input  wire logic                           tick_in,
  input  wire logic [ebtcp_pkg::RATE_W-1:0]   rate_in,
  // Divided output
  output logic                                tap_out
);

  ebtcp_pkg::ebtcp_psc_state_t r_reg;
  ebtcp_pkg::ebtcp_psc_state_t r_next;

  // Clear wins over a tick in the same cycle so a count write restarts the ratio cleanly.
  always_comb begin
    r_next = r_reg;
    if (clear_in) begin
      r_next.div = ebtcp_pkg::PSC_RESET;
    end else if (tick_in) begin
      r_next.div = r_reg.div + ebtcp_pkg::PSC_ONE;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg.div <= ebtcp_pkg::PSC_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Bit n rises once every 2^(n+1) ticks, giving 1:2 up to 1:256.
  assign tap_out = r_reg.div[rate_in];

endmodule : ebtcp_prescaler

// File: verilog/ebtcp_timer.sv
// Top of the prescaled 8-bit timer/counter with its APB register slave.
module ebtcp_timer (
  // Clock and reset
  input  wire logic                           CLK_SYS_IN,
  input  wire logic                           RESET_N_IN,
  // APB slave
  input  wire logic                           PSEL_IN,
  input  wire logic                           PENABLE_IN,
  input  wire logic                           PWRITE_IN,
  input  wire logic [ebtcp_pkg::ADDR_W-1:0]   PADDR_IN,
  input  wire logic [ebtcp_pkg::DATA_W-1:0]   PWDATA_IN,
  output logic      [ebtcp_pkg::DATA_W-1:0]   PRDATA_OUT,
  output logic                                PREADY_OUT,
  output logic                                PSLVERR_OUT,
  // Pins and system
  input  wire logic                           EXTERNAL_COUNT_INPUT_IN,
  input  wire logic                           SLEEP_IN,
  output logic                                IRQ_OUT
);

  ebtcp_pkg::ebtcp_state_t r_reg;
  ebtcp_pkg::ebtcp_state_t r_next;

  logic instr_tick;
  logic sample_phase;
  logic strobe;
  logic ext_edge;
  logic psc_tick;
  logic psc_clear;
  logic psc_tap;
  logic level;
  logic src_inc;
  logic inc;
  logic setup;
  logic access;
  logic mapped;
  logic wr_count;
  logic wr_option;
  logic wr_intctl;
  logic ovf_set;
  logic [7:0] rd_mux;

  // The prescaler count has no address at all; only its tap is visible here.
  ebtcp_prescaler i_ebtcp_prescaler (
    .clk_in     (CLK_SYS_IN),
    .reset_n_in (RESET_N_IN),
    .clear_in   (psc_clear),
    .tick_in    (psc_tick),
    .rate_in    (r_reg.opt.rate),
    .tap_out    (psc_tap)
  );

  always_comb begin
    r_next = r_reg;

    // APB decode.
    setup  = PSEL_IN && !PENABLE_IN;
    access = PSEL_IN && PENABLE_IN;
    if (PADDR_IN == ebtcp_pkg::ADDR_COUNT) begin
      mapped = 1'b1;
      rd_mux = r_reg.count;
    end else if (PADDR_IN == ebtcp_pkg::ADDR_OPTION) begin
      mapped = 1'b1;
      rd_mux = ebtcp_pkg::BYTE_ZERO;
      rd_mux[ebtcp_pkg::OPT_SRC_BIT]    = r_reg.opt.src_sel;
      rd_mux[ebtcp_pkg::OPT_EDGE_BIT]   = r_reg.opt.edge_sel;
      rd_mux[ebtcp_pkg::OPT_ASSIGN_BIT] = r_reg.opt.assign_n;
      rd_mux[ebtcp_pkg::OPT_RATE_LSB +: ebtcp_pkg::RATE_W] = r_reg.opt.rate;
    end else if (PADDR_IN == ebtcp_pkg::ADDR_INTCTL) begin
      mapped = 1'b1;
      rd_mux = ebtcp_pkg::BYTE_ZERO;
      rd_mux[ebtcp_pkg::INT_GLOBAL_BIT] = r_reg.ictl.global_ie;
      rd_mux[ebtcp_pkg::INT_PERIPH_BIT] = r_reg.ictl.periph_ie;
      rd_mux[ebtcp_pkg::INT_IE_BIT]   = r_reg.ictl.ovf_ie;
      rd_mux[ebtcp_pkg::INT_FLAG_BIT] = r_reg.ictl.ovf_flag;
    end else begin
      mapped = 1'b0;
      rd_mux = ebtcp_pkg::BYTE_ZERO;
    end
    wr_count  = access && PWRITE_IN && (PADDR_IN == ebtcp_pkg::ADDR_COUNT);
    wr_option = access && PWRITE_IN && (PADDR_IN == ebtcp_pkg::ADDR_OPTION);
    wr_intctl = access && PWRITE_IN && (PADDR_IN == ebtcp_pkg::ADDR_INTCTL);

    // Read data is captured in the setup cycle so the bus sees a registered value.
    if (setup) begin
      r_next.rdata = rd_mux;
    end

    // Instruction phase counter; it stops in sleep so nothing advances.
    instr_tick = 1'b0;
    if (!SLEEP_IN) begin
      r_next.phase = r_reg.phase + ebtcp_pkg::PHASE_ONE;
      instr_tick   = (r_reg.phase == ebtcp_pkg::PHASE_Q4);
    end
    sample_phase = (r_reg.phase == ebtcp_pkg::PHASE_Q2) ||
                   (r_reg.phase == ebtcp_pkg::PHASE_Q4);

    // Three-stage pin synchroniser; a new level is accepted once stages two and three agree.
    r_next.sync1 = EXTERNAL_COUNT_INPUT_IN;
    r_next.sync2 = r_reg.sync1;
    r_next.sync3 = r_reg.sync2;
    ext_edge = 1'b0;
    if (r_reg.sync2 == r_reg.sync3) begin
      r_next.ext_lvl = r_reg.sync3;
      ext_edge = (r_reg.sync3 != r_reg.ext_lvl) &&
                 (r_reg.sync3 ^ r_reg.opt.edge_sel);
    end

    // Prescaler only runs when assigned here.
    psc_tick = !SLEEP_IN && !r_reg.opt.assign_n &&
               (r_reg.opt.src_sel ? ext_edge : instr_tick);
    psc_clear = wr_count && !r_reg.opt.assign_n;

    // Active edges are turned into rising edges of one level, then sampled.
    if (r_reg.opt.src_sel && r_reg.opt.assign_n) begin
      level = r_reg.ext_lvl ^ r_reg.opt.edge_sel;
    end else begin
      level = psc_tap;
    end
    strobe = !SLEEP_IN && (r_reg.opt.src_sel ? sample_phase : 1'b1);
    if (strobe) begin
      r_next.samp = level;
    end
    if (!r_reg.opt.src_sel && r_reg.opt.assign_n) begin
      src_inc = instr_tick;
    end else begin
      src_inc = strobe && level && !r_reg.samp;
    end

    // Pulses inside the stall are simply lost.
    inc = src_inc && (r_reg.stall == ebtcp_pkg::ST_RUN) && !SLEEP_IN;

    case (r_reg.stall)
      ebtcp_pkg::ST_WAIT2: begin
        if (instr_tick) begin
          r_next.stall = ebtcp_pkg::ST_WAIT1;
        end
      end
      ebtcp_pkg::ST_WAIT1: begin
        if (instr_tick) begin
          r_next.stall = ebtcp_pkg::ST_RUN;
        end
      end
      default: begin
        r_next.stall = ebtcp_pkg::ST_RUN;
      end
    endcase

    ovf_set = inc && (r_reg.count == ebtcp_pkg::COUNT_MAX);
    if (inc) begin
      r_next.count = r_reg.count + ebtcp_pkg::COUNT_ONE;
    end

    if (wr_count) begin
      r_next.count = PWDATA_IN[ebtcp_pkg::CNT_W-1:0];
      r_next.stall = ebtcp_pkg::ST_WAIT2;
    end
    if (wr_option) begin
      r_next.opt.src_sel  = PWDATA_IN[ebtcp_pkg::OPT_SRC_BIT];
      r_next.opt.edge_sel = PWDATA_IN[ebtcp_pkg::OPT_EDGE_BIT];
      r_next.opt.assign_n = PWDATA_IN[ebtcp_pkg::OPT_ASSIGN_BIT];
      r_next.opt.rate     = PWDATA_IN[ebtcp_pkg::OPT_RATE_LSB +: ebtcp_pkg::RATE_W];
    end
    if (wr_intctl) begin
      r_next.ictl.global_ie = PWDATA_IN[ebtcp_pkg::INT_GLOBAL_BIT];
      r_next.ictl.periph_ie = PWDATA_IN[ebtcp_pkg::INT_PERIPH_BIT];
      r_next.ictl.ovf_ie   = PWDATA_IN[ebtcp_pkg::INT_IE_BIT];
      r_next.ictl.ovf_flag = r_reg.ictl.ovf_flag & PWDATA_IN[ebtcp_pkg::INT_FLAG_BIT];
    end
    // A rollover in the clearing cycle still leaves the flag set.
    if (ovf_set) begin
      r_next.ictl.ovf_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      r_reg.count        <= ebtcp_pkg::COUNT_RESET;
      r_reg.opt.src_sel  <= ebtcp_pkg::OPT_BIT_RESET;
      r_reg.opt.edge_sel <= ebtcp_pkg::OPT_BIT_RESET;
      r_reg.opt.assign_n <= ebtcp_pkg::OPT_BIT_RESET;
      r_reg.opt.rate     <= ebtcp_pkg::OPT_RATE_RESET;
      r_reg.ictl         <= '0;
      r_reg.stall        <= ebtcp_pkg::ST_RUN;
      r_reg.phase        <= '0;
      r_reg.sync1        <= 1'b0;
      r_reg.sync2        <= 1'b0;
      r_reg.sync3        <= 1'b0;
      r_reg.ext_lvl      <= 1'b0;
      // The reset mode counts falling pin edges, so the sampled level idles high; a low
      // reset value here would be taken for an edge at the first sample point.
      r_reg.samp         <= ebtcp_pkg::OPT_BIT_RESET;
      r_reg.rdata        <= ebtcp_pkg::BYTE_ZERO;
    end else begin
      r_reg <= r_next;
    end
  end

  // Zero-wait-state slave; unmapped addresses answer with an error and zero data.
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign PRDATA_OUT  = {ebtcp_pkg::UPPER_ZERO, r_reg.rdata};
  // The enable acts as the mask; the core-level enables are only stored.
  assign IRQ_OUT     = r_reg.ictl.ovf_flag && r_reg.ictl.ovf_ie;

endmodule : ebtcp_timer
